// *** dv/testbench.sv ***
`timescale 1ns/10ps
module testbench;
  typedef struct {
    string       name;
    logic [31:0] exp;
    logic [31:0] mask;
    logic        err;
  } xcg_note_t;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic                  clk;
  logic                  sys_rst;
  xcg_pkg::xcg_apb_req_t apb_req;
  xcg_pkg::xcg_apb_rsp_t apb_rsp;
  logic                  amplitude_detect;
  logic                  supply_monitor;
  logic                  button_power_on_n;
  logic                  pin_power_on;
  logic                  bit_check_ok;
  logic                  clk_out_pin;
  logic                  dclk_tick;
  logic                  bit_tick;
  logic                  load_cap_full;
  logic                  band_select;
  logic [5:0]            synth_int_part;
  logic [12:0]           synth_frequency_word;
  int                    rise_count;
  real                   high_ns;
  real                   low_ns;
  int                    miscompares;
  int                    samples_checked;
  int                    cycles;
  int                    n;
  logic [31:0]           lfsr;
  logic [12:0]           w;
  xcg_note_t             note;
  xcg_note_t             notes[$];
  logic [12:0]           words[4] = '{13'h0eda, 13'h0edb, 13'h0fd5, 13'h0fd6};

  xcg_clock_gen xcg_clock_gen_i (
    .clk                 (clk),
    .sys_rst             (sys_rst),
    .apb_req             (apb_req),
    .apb_rsp             (apb_rsp),
    .amplitude_detect    (amplitude_detect),
    .supply_monitor      (supply_monitor),
    .button_power_on_n   (button_power_on_n),
    .pin_power_on        (pin_power_on),
    .bit_check_ok        (bit_check_ok),
    .clk_out_pin         (clk_out_pin),
    .dclk_tick           (dclk_tick),
    .bit_tick            (bit_tick),
    .load_cap_full       (load_cap_full),
    .band_select         (band_select),
    .synth_int_part      (synth_int_part),
    .synth_frequency_word(synth_frequency_word)
  );

  xcg_mcu_model xcg_mcu_model_i (
    .clk_out_pin(clk_out_pin),
    .rise_count (rise_count),
    .high_ns    (high_ns),
    .low_ns     (low_ns)
  );

  always #2 clk = ~clk;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic summarize;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  function automatic logic [31:0] next_rand(input logic [31:0] l);
    return (l >> 1) ^ (l[0] ? 32'h80200003 : 32'h0);
  endfunction

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    apb_req <= '{psel:1'b1, penable:1'b0, pwrite:wr, paddr:a, pwdata:d};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (apb_rsp.pready !== 1'b1 && k < 20);
    if (k >= 20) chk("pready", 32'h1, 32'h0);
    apb_req <= '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m, input logic er, input string nm);
    notes.push_back('{nm, e, m, er});
    apb(1'b0, a, 32'h0);
  endtask

  // Waits out any period in flight, then looks for fresh rising edges.
  task automatic clk_run(input logic on, input string nm);
    int c;
    repeat (12) @(posedge clk);
    c = rise_count;
    repeat (30) @(posedge clk);
    chk(nm, 32'(on), 32'(rise_count != c));
  endtask

  task automatic gap(input logic sel, output int cnt);
    int k;
    k = 0;
    cnt = 0;
    while (k < 2 && cnt < 4000) begin
      @(posedge clk);
      cnt++;
      if ((sel ? bit_tick : dclk_tick) === 1'b1) k++;
    end
    cnt = 0;
    do begin
      @(posedge clk);
      cnt++;
    end while ((sel ? bit_tick : dclk_tick) !== 1'b1 && cnt < 4000);
  endtask

  // ----------------------------------------------------------------
  // Read data checking
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (apb_req.psel && apb_req.penable && !apb_req.pwrite &&
        apb_rsp.pready === 1'b1) begin
      if (notes.size() == 0) begin
        chk("unexpected read", 32'h0, 32'h1);
      end else begin
        note = notes.pop_front();
        chk(note.name, note.exp & note.mask, apb_rsp.prdata & note.mask);
        chk({note.name, " slverr"}, 32'(note.err), 32'(apb_rsp.pslverr));
      end
    end
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    apb_req = '0;
    amplitude_detect = 1'b0;
    supply_monitor = 1'b0;
    button_power_on_n = 1'b1;
    pin_power_on = 1'b0;
    bit_check_ok = 1'b0;
    miscompares = 0;
    samples_checked = 0;
    cycles = 0;
    lfsr = 32'h82b55a4c;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    chk("int part", 32'h20, 32'(synth_int_part));
    rd(xcg_pkg::OFS_CTRL, 32'h3, 32'hffffffff, 1'b0, "ctrl");
    rd(xcg_pkg::OFS_SYNTH, 32'hf00, 32'hffffffff, 1'b0, "synth");
    rd(xcg_pkg::OFS_XLIM, 32'h1, 32'hffffffff, 1'b0, "xlim");
    rd(8'h10, 32'h0, 32'hffffffff, 1'b1, "unmapped");
    pin_power_on <= 1'b1;
    clk_run(1'b0, "off without supply");
    rd(xcg_pkg::OFS_STATUS, 32'h8, 32'hf, 1'b0, "status");
    supply_monitor <= 1'b1;
    clk_run(1'b0, "off without amplitude");
    amplitude_detect <= 1'b1;
    clk_run(1'b1, "on by power flag");
    chk("high ns x10", 32'd60, 32'($rtoi(high_ns * 10.0)));
    chk("low ns x10", 32'd60, 32'($rtoi(low_ns * 10.0)));
    rd(xcg_pkg::OFS_STATUS, 32'h2f, 32'h3f, 1'b0, "status on");
    apb(1'b1, xcg_pkg::OFS_CTRL, 32'h0);
    clk_run(1'b0, "off by permit");
    chk("last high x10", 32'd60, 32'($rtoi(high_ns * 10.0)));
    apb(1'b1, xcg_pkg::OFS_CTRL, 32'h1);
    clk_run(1'b0, "off by request");
    pin_power_on <= 1'b0;
    apb(1'b1, xcg_pkg::OFS_STATUS, 32'h8);
    apb(1'b1, xcg_pkg::OFS_CTRL, 32'h3);
    clk_run(1'b0, "armed, no wake");
    button_power_on_n <= 1'b0;
    repeat (6) @(posedge clk);
    button_power_on_n <= 1'b1;
    clk_run(1'b1, "on by button");
    amplitude_detect <= 1'b0;
    clk_run(1'b0, "off by amplitude");
    amplitude_detect <= 1'b1;
    for (int m = 1; m <= 4; m++) begin
      apb(1'b1, xcg_pkg::OFS_CTRL, 32'h0);
      apb(1'b1, xcg_pkg::OFS_CTRL, 32'h3 | (m << 5));
      clk_run(1'b0, "armed in mode");
      bit_check_ok <= 1'b1;
      @(posedge clk);
      bit_check_ok <= 1'b0;
      clk_run(m >= 2, "on by bit check");
    end
    for (int m = 0; m <= 5; m++) begin
      apb(1'b1, xcg_pkg::OFS_CTRL, 32'(m << 5));
      repeat (3) @(posedge clk);
      chk("load cap", 32'(m != 0 && m != 5), 32'(load_cap_full));
    end
    gap(1'b0, n);
    chk("dclk gap", 32'd16, 32'(n));
    apb(1'b1, xcg_pkg::OFS_XLIM, 32'h3);
    for (int r = 0; r <= 3; r++) begin
      apb(1'b1, xcg_pkg::OFS_CTRL, 32'(r << 3));
      gap(1'b1, n);
      chk("bit gap", 32'(3 * (8 >> r) * 16), 32'(n));
    end
    apb(1'b1, xcg_pkg::OFS_CTRL, 32'h4);
    repeat (3) @(posedge clk);
    chk("band", 32'h1, 32'(band_select));
    chk("int part", 32'h18, 32'(synth_int_part));
    for (int i = 0; i < 8; i++) begin
      lfsr = next_rand(lfsr);
      w = (i < 4) ? words[i] : lfsr[12:0];
      apb(1'b1, xcg_pkg::OFS_SYNTH, {19'h0, w});
      rd(xcg_pkg::OFS_SYNTH, {19'h0, w}, 32'hffffffff, 1'b0, "synth");
      chk("word", 32'(w), 32'(synth_frequency_word));
      rd(xcg_pkg::OFS_STATUS, 32'(w >= 13'h0edb && w <= 13'h0fd5) << 5,
         32'h20, 1'b0, "word range");
    end
    summarize();
  end
endmodule

// *** dv/xcg_mcu_model.sv ***
`timescale 1ns/10ps
module xcg_mcu_model (
  // Clock from the transceiver
  input  wire logic clk_out_pin,
  // Measurements
  output int        rise_count,
  output real       high_ns,
  output real       low_ns
);
  real t_rise;
  real t_fall;

  // A controller clocked by the pin only sees its edges, so the model
  // counts rising edges and times each phase of the last period.
  initial begin
    rise_count = 0;
    high_ns = 0.0;
    low_ns = 0.0;
    t_rise = 0.0;
    t_fall = 0.0;
  end

  always @(posedge clk_out_pin) begin
    rise_count = rise_count + 1;
    low_ns = $realtime - t_fall;
    t_rise = $realtime;
  end

  always @(negedge clk_out_pin) begin
    high_ns = $realtime - t_rise;
    t_fall = $realtime;
  end
endmodule

// *** verilog/xcg_clock_gen.sv ***
// Function
// - Output pin carries oscillator clock divided by three.
// - Divided output has equal high and low.
// - Permit bit low keeps output off always.
// - Request bit low also keeps output off.
// - Bit-check, button event or power-on flag enable.
// - Amplitude good rises after oscillator start-up time.
// - Output needs amplitude good, both bits, supply good.
// - Digital clock is oscillator divided by sixteen.
// - Digital clock times polling and transmit bit rate.
// - Bit period is limit times eight/four/two/one periods.
// - Idle and sleep drop part of load capacitance.
// - Synth word from band bit and thirteen bits.
// - RF integer part and FSK offsets follow band.
// - Supply monitor gives the logic supply good level.
// - Output waits for supply and oscillator start-up.
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/10ps
module xcg_clock_gen (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  // Register bus
  input  wire xcg_pkg::xcg_apb_req_t apb_req,
  output xcg_pkg::xcg_apb_rsp_t      apb_rsp,
  // Analog status and pins
  input  wire logic                  amplitude_detect,
  input  wire logic                  supply_monitor,
  input  wire logic                  button_power_on_n,
  input  wire logic                  pin_power_on,
  // Receiver logic
  input  wire logic                  bit_check_ok,
  // Clock outputs
  output logic                       clk_out_pin,
  output logic                       dclk_tick,
  output logic                       bit_tick,
  // Oscillator and synthesizer
  output logic                       load_cap_full,
  output logic                       band_select,
  output logic [5:0]                 synth_int_part,
  output logic [12:0]                synth_frequency_word
);

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  logic       osc_amp_raw;
  logic       logic_supply_good;
  logic       button_n_s;
  logic       pin_on_s;
  logic       button_n_d;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync_a     <= 4'h4;
      sync_b     <= 4'h4;
      button_n_d <= 1'b1;
    end else begin
      sync_a     <= {pin_power_on, button_power_on_n,
                     supply_monitor, amplitude_detect};
      sync_b     <= sync_a;
      button_n_d <= sync_b[2];
    end
  end

  assign osc_amp_raw       = sync_b[0];
  assign logic_supply_good = sync_b[1];
  assign button_n_s        = sync_b[2];
  assign pin_on_s          = sync_b[3];

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [7:0]  ctrl;
  logic [12:0] synth;
  logic [7:0]  xlim;
  logic        power_on_flag;
  logic        oscillator_amplitude_good;
  logic        clk_running;
  logic        button_event;
  logic        wr_en;
  logic        setup;
  logic [2:0]  op_mode;
  logic [1:0]  bit_rate_range;
  logic        permit;
  logic        request;
  logic        synth_frequency_word_ok;

  assign setup   = apb_req.psel && !apb_req.penable;
  assign wr_en   = apb_req.psel && apb_req.penable && apb_rsp.pready
                   && apb_req.pwrite;
  assign op_mode = ctrl[xcg_pkg::CTRL_MODE +: 3];
  assign bit_rate_range = ctrl[xcg_pkg::CTRL_RANGE +: 2];
  assign permit  = ctrl[xcg_pkg::CTRL_PERMIT];
  assign request = ctrl[xcg_pkg::CTRL_REQUEST];
  assign button_event = button_n_d && !button_n_s;
  assign synth_frequency_word_ok = (synth >= xcg_pkg::SYNTH_FREQUENCY_WORD_SAFE_MIN)
                   && (synth <= xcg_pkg::SYNTH_FREQUENCY_WORD_SAFE_MAX);

  function automatic logic is_addr(input logic [7:0] a,
                                   input logic [7:0] ofs);
    is_addr = (a == ofs);
  endfunction

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl  <= xcg_pkg::RST_CTRL;
      synth <= xcg_pkg::RST_SYNTH;
      xlim  <= xcg_pkg::RST_XLIM;
    end else if (wr_en) begin
      if (is_addr(apb_req.paddr, xcg_pkg::OFS_CTRL)) begin
        ctrl <= apb_req.pwdata[7:0];
      end
      if (is_addr(apb_req.paddr, xcg_pkg::OFS_SYNTH)) begin
        synth <= apb_req.pwdata[12:0];
      end
      if (is_addr(apb_req.paddr, xcg_pkg::OFS_XLIM)) begin
        xlim <= apb_req.pwdata[7:0];
      end
    end
  end

  // A pin event in the same cycle as a software clear keeps the flag set.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      power_on_flag <= 1'b0;
    end else if (pin_on_s) begin
      power_on_flag <= 1'b1;
    end else if (wr_en && is_addr(apb_req.paddr, xcg_pkg::OFS_STATUS)
                 && apb_req.pwdata[xcg_pkg::ST_POWER_ON]) begin
      power_on_flag <= 1'b0;
    end
  end

  // Answers are prepared in the setup cycle, so every access takes one
  // access cycle and the bus outputs come straight from flip-flops.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      apb_rsp <= '0;
    end else if (setup) begin
      apb_rsp.pready  <= 1'b1;
      apb_rsp.pslverr <= 1'b0;
      apb_rsp.prdata  <= 32'h0000_0000;
      case (apb_req.paddr)
        xcg_pkg::OFS_CTRL: begin
          apb_rsp.prdata[7:0] <= ctrl;
        end
        xcg_pkg::OFS_SYNTH: begin
          apb_rsp.prdata[12:0] <= synth;
        end
        xcg_pkg::OFS_XLIM: begin
          apb_rsp.prdata[7:0] <= xlim;
        end
        xcg_pkg::OFS_STATUS: begin
          apb_rsp.prdata[5:0] <= {synth_frequency_word_ok, load_cap_full, power_on_flag,
                                  logic_supply_good,
                                  oscillator_amplitude_good, clk_running};
        end
        default: begin
          apb_rsp.pslverr <= 1'b1;
        end
      endcase
    end else begin
      apb_rsp.pready  <= 1'b0;
      apb_rsp.pslverr <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Oscillator start-up qualification
  // ----------------------------------------------------------------------
  logic [15:0] startup_cnt;
  logic        startup_done;

  assign startup_done =
    (startup_cnt == 16'(xcg_pkg::STARTUP_CYC));

  // The detector output is trusted only after the shortest start-up time,
  // since a weak early amplitude can pass the detector briefly.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      startup_cnt <= 16'h0000;
    end else if (!startup_done) begin
      startup_cnt <= startup_cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      oscillator_amplitude_good <= 1'b0;
    end else begin
      oscillator_amplitude_good <= startup_done && osc_amp_raw;
    end
  end

  // ----------------------------------------------------------------------
  // Clock output gating
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    XCG_OFF,
    XCG_ARMED,
    XCG_ON
  } xcg_gate_t;

  xcg_gate_t gate;
  logic      wake;
  logic      gate_en;
  logic      bitcheck_mode;

  assign bitcheck_mode = (op_mode == xcg_pkg::MODE_RX)
                         || (op_mode == xcg_pkg::MODE_POLL)
                         || (op_mode == xcg_pkg::MODE_FD);
  assign wake = (bit_check_ok && bitcheck_mode) || button_event
                || power_on_flag;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gate <= XCG_OFF;
    end else begin
      case (gate)
        XCG_OFF: begin
          if (permit && request) begin
            gate <= XCG_ARMED;
          end
        end
        XCG_ARMED: begin
          if (!permit || !request) begin
            gate <= XCG_OFF;
          end else if (wake) begin
            gate <= XCG_ON;
          end
        end
        XCG_ON: begin
          if (!permit || !request) begin
            gate <= XCG_OFF;
          end
        end
        default: begin
          gate <= XCG_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gate_en <= 1'b0;
    end else begin
      gate_en <= (gate == XCG_ON) && permit && request
                 && oscillator_amplitude_good
                 && logic_supply_good;
    end
  end

  xcg_div3 u_div3 (
    .clk     (clk),
    .sys_rst (sys_rst),
    .en      (gate_en),
    .clk_out (clk_out_pin),
    .running (clk_running)
  );

  // ----------------------------------------------------------------------
  // Digital clock and bit timing
  // ----------------------------------------------------------------------
  logic [3:0]  dclk_cnt;
  logic [10:0] bit_cnt;
  logic [10:0] bit_limit;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dclk_cnt  <= 4'h0;
      dclk_tick <= 1'b0;
    end else begin
      dclk_cnt  <= dclk_cnt + 4'h1;
      dclk_tick <= (dclk_cnt == 4'(xcg_pkg::DCLK_DIV - 1));
    end
  end

  // Range 0 is the slowest: eight digital periods for each limit step.
  assign bit_limit = {3'h0, xlim} << (2'h3 - bit_rate_range);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bit_cnt  <= 11'h000;
      bit_tick <= 1'b0;
    end else begin
      bit_tick <= 1'b0;
      if (dclk_tick) begin
        if (bit_cnt + 11'h001 >= bit_limit) begin
          bit_cnt  <= 11'h000;
          bit_tick <= 1'b1;
        end else begin
          bit_cnt <= bit_cnt + 11'h001;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Load capacitance and synthesizer word
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      load_cap_full <= 1'b0;
    end else begin
      load_cap_full <= (op_mode != xcg_pkg::MODE_IDLE)
                       && (op_mode != xcg_pkg::MODE_SLEEP);
    end
  end

  // The synthesizer adds one half to the integer part and the 24.5 offset
  // to the fraction itself; the FSK deviation is applied there as well.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      band_select          <= 1'b0;
      synth_int_part       <= xcg_pkg::INT_HIGH_BAND;
      synth_frequency_word <= xcg_pkg::RST_SYNTH;
    end else begin
      band_select          <= ctrl[xcg_pkg::CTRL_BAND];
      synth_int_part       <= ctrl[xcg_pkg::CTRL_BAND] ?
                              xcg_pkg::INT_LOW_BAND :
                              xcg_pkg::INT_HIGH_BAND;
      synth_frequency_word <= synth;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_permit_off: assert property (@(posedge clk) disable iff (sys_rst)
    !permit |=> !gate_en)
    else $error("clock enable with permit bit low");
  a_request_off: assert property (@(posedge clk) disable iff (sys_rst)
    (permit && !request) |=> !gate_en)
    else $error("clock enable with request bit low");
  a_enable_cond: assert property (@(posedge clk) disable iff (sys_rst)
    gate_en |-> $past(oscillator_amplitude_good && logic_supply_good))
    else $error("clock enabled without amplitude and supply good");
  a_wake_on: assert property (@(posedge clk) disable iff (sys_rst)
    (gate == XCG_ARMED && permit && request && wake) |=> gate == XCG_ON)
    else $error("wake event did not turn clock on");
  a_osc_startup: assert property (@(posedge clk) disable iff (sys_rst)
    !startup_done |-> !oscillator_amplitude_good)
    else $error("amplitude good before start-up time");
  a_dclk_period: assert property (@(posedge clk) disable iff (sys_rst)
    dclk_tick |=> !dclk_tick [*8] ##8 dclk_tick)
    else $error("digital clock tick spacing wrong");
  a_load_cap: assert property (@(posedge clk) disable iff (sys_rst)
    (op_mode == xcg_pkg::MODE_SLEEP) |=> !load_cap_full)
    else $error("load capacitance full in sleep");
  a_band_int: assert property (@(posedge clk) disable iff (sys_rst)
    ctrl[xcg_pkg::CTRL_BAND] |=> synth_int_part == xcg_pkg::INT_LOW_BAND)
    else $error("integer part does not follow band select");

  c_clock_on: cover property (@(posedge clk) disable iff (sys_rst)
    $rose(clk_running));
  c_button_wake: cover property (@(posedge clk) disable iff (sys_rst)
    button_event && gate == XCG_ARMED);
  c_bit_tick: cover property (@(posedge clk) disable iff (sys_rst)
    bit_tick && bit_rate_range == 2'h3);
  c_clock_off: cover property (@(posedge clk) disable iff (sys_rst)
    $fell(clk_running));

endmodule

// *** verilog/xcg_div3.sv ***
`timescale 1ns/10ps
module xcg_div3 (
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Control
  input  wire logic en,
  // Result
  output logic      clk_out,
  output logic      running
);

  logic [1:0] phase;
  logic       rise_half;
  logic       fall_half;

  always_ff @(posedge clk) begin
    if (sys_rst || !running) begin
      phase <= 2'h0;
    end else if (phase == 2'h2) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  // Starting and stopping only at the end of a whole period keeps every
  // high and low phase on the pin at its full length.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      running <= 1'b0;
    end else if (!running || phase == 2'h2) begin
      running <= en;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rise_half <= 1'b0;
    end else begin
      rise_half <= running && (phase != 2'h2);
    end
  end

  a_div3_shape: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(rise_half) |=> rise_half ##1 !rise_half)
    else $error("divided clock not three cycles");

  // The falling-edge copy trims the pulse by half a cycle, giving
  // 1.5 high and 1.5 low clock periods without a second clock.
  always_ff @(negedge clk) begin
    if (sys_rst) begin
      fall_half <= 1'b0;
    end else begin
      fall_half <= rise_half;
    end
  end

  assign clk_out = rise_half && fall_half;

endmodule

// *** verilog/xcg_pkg.sv ***
package xcg_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_SYNTH  = 8'h04;
  localparam logic [7:0] OFS_XLIM   = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;

  // Control register fields.
  localparam int CTRL_PERMIT  = 0;
  localparam int CTRL_REQUEST = 1;
  localparam int CTRL_BAND    = 2;
  localparam int CTRL_RANGE   = 3;
  localparam int CTRL_MODE    = 5;

  // Status register fields.
  localparam int ST_CLK_ACTIVE = 0;
  localparam int ST_OSC_GOOD   = 1;
  localparam int ST_SUPPLY     = 2;
  localparam int ST_POWER_ON   = 3;
  localparam int ST_LOAD_CAP   = 4;
  localparam int ST_SYNTH_FREQUENCY_WORD_OK    = 5;

  // Values after reset.
  localparam logic [7:0]  RST_CTRL  = 8'h03;
  localparam logic [12:0] RST_SYNTH = 13'h0f00;
  localparam logic [7:0]  RST_XLIM  = 8'h01;

  // Operating modes held in the control register.
  localparam logic [2:0] MODE_IDLE  = 3'h0;
  localparam logic [2:0] MODE_TX    = 3'h1;
  localparam logic [2:0] MODE_RX    = 3'h2;
  localparam logic [2:0] MODE_POLL  = 3'h3;
  localparam logic [2:0] MODE_FD    = 3'h4;
  localparam logic [2:0] MODE_SLEEP = 3'h5;

  // ----------------------------------------------------------------------
  // Clock figures
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ        = 250;
  localparam int CLKOUT_DIV     = 3;
  localparam int DCLK_DIV       = 16;
  localparam int TAU_NS         = 40;
  localparam int TAU_MIN_COUNT  = 10;
  localparam int STARTUP_CYC    = (TAU_MIN_COUNT * TAU_NS * CLK_MHZ + 999)
                                  / 1000;

  // Synthesizer figures.
  localparam logic [5:0]  INT_LOW_BAND  = 6'h18;
  localparam logic [5:0]  INT_HIGH_BAND = 6'h20;
  localparam logic [12:0] SYNTH_FREQUENCY_WORD_SAFE_MIN = 13'h0edb;
  localparam logic [12:0] SYNTH_FREQUENCY_WORD_SAFE_MAX = 13'h0fd5;
  localparam int          FRAC_DENOM    = 16384;
  localparam int          FSK_DEV_LO_HZ = 18650;
  localparam int          FSK_DEV_HI_HZ = 19410;

  // ----------------------------------------------------------------------
  // Bus carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } xcg_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } xcg_apb_rsp_t;

endpackage
